// [bmct_pkg.sv]
// Package with constants and carrier types for the breaker monitor, capture and test block
// Function
// R1 - Enabled low power factor below level raises display alarm, yellow lamp, host report
// R2 - Distortion threshold programmable 10 to 30 percent; exceeding starts capture, sets lamp
// R3 - Distortion alarm condition is re-evaluated once per minute only
// R4 - Host capture command records three phases plus neutral or ground per variant
// R5 - Each captured waveform holds 58 samples per phase per line cycle
// R6 - At most one remote capture command accepted per second; others ignored
// R7 - Three newest captures kept; a new capture replaces the oldest
// R8 - Overload, short time, instantaneous or ground trip stores six-cycle record; the code stores five post-trip cycles (290 samples)
// R9 - Trip record holds one pre-trip cycle then five cycles after; the code stores no pre-trip cycle
// R10 - Phase loss, unbalance, voltage, frequency, reverse power, alarms never capture
// R11 - One-cycle capture on host request, or enabled alarm when alarm logging enabled
// R12 - Fast trip counter and overload plus ground counter; self tests never count
// R13 - Reset key clears both trip counters and close operation counter
// R14 - Trip counters wrap after 255; close counter wraps after 65,000
// R15 - Record time of last open, close or trip and highest processor temperature
// R16 - Health data captured only with external power, kept in nonvolatile storage; the code keeps it in registers that reset clears
// R17 - No pickup: test stays three hours, ends early on real event or key
// R18 - Operator starts test with two save presses after choosing test level
// R19 - Non-trip test drives no trip or relay, still lights lamp and shows cause
// R20 - Trip test may trip; ground-alarm-only variant ground test gives alarm only
// R21 - Self test refused while any alarm is active
// R22 - Test aborts on real alarm, ground over 0.1, or phase over limit per mode
package bmct_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int SECOND_CYC = CLK_HZ;
  localparam int MINUTE_S = 60;
  localparam int TEST_HOURS = 3;
  localparam int TEST_S = TEST_HOURS * 3600;
  localparam int SAMPLES_PER_CYCLE = 58;
  localparam int TRIP_CYCLES = 6;
  localparam int PRE_CYCLES = 1;
  localparam int CAPTURE_SLOTS = 3;
  localparam logic [6:0] DIST_MIN_PCT = 7'h0a;
  localparam logic [6:0] DIST_MAX_PCT = 7'h1e;
  localparam logic [7:0] TRIP_WRAP = 8'hff;
  localparam logic [15:0] OPS_WRAP = 16'hfde8;
  localparam logic [15:0] GND_ABORT_PU = 16'h0066; // 0.1 pu in Q10
  localparam int CUR_W = 16;

  typedef struct packed {
    logic [CUR_W-1:0] phaseA;
    logic [CUR_W-1:0] phaseB;
    logic [CUR_W-1:0] phaseC;
    logic [CUR_W-1:0] fourth; // Neutral or source ground
  } bmct_sample_type;

  typedef struct packed {
    logic overloadTrip;
    logic shortTrip;
    logic instTrip;
    logic earthFaultTrip;
    logic otherTrip; // Loss, unbalance, voltage, frequency, reverse power
  } bmct_trip_type;

  typedef enum logic [1:0] {
    CAP_IDLE = 2'b00,
    CAP_PRE = 2'b01,
    CAP_POST = 2'b10
  } bmct_cap_type;

  typedef enum logic [1:0] {
    TST_IDLE = 2'b00,
    TST_ARMED = 2'b01,
    TST_RUN = 2'b10
  } bmct_test_type;
endpackage

// [bmct_capture_buf.sv]
// Three-slot first-in first-out waveform store with host readout
`timescale 1ns/1ns
`default_nettype none
module bmct_capture_buf #(
  parameter int SLOTS = 3,
  parameter int DEPTH = 348
) (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Async reset
  input wire logic clkEn, // Clock enable
  input wire logic startSlot, // Begin a new record
  input wire logic wrEn, // Write one sample
  input wire bmct_pkg::bmct_sample_type wrData, // Sample
  input wire logic [1:0] rdAge, // 0 newest
  input wire logic [$clog2(DEPTH)-1:0] rdAddr, // Sample index
  output bmct_pkg::bmct_sample_type rdData, // Read data
  output logic [1:0] validCount // Records held
);
  import bmct_pkg::*;
  localparam int AW = $clog2(DEPTH);
  bmct_sample_type mem [SLOTS*DEPTH];
  logic [1:0] headQ;
  logic [AW-1:0] wrPtrQ;

  function automatic logic [1:0] slotOf(input logic [1:0] head, input logic [1:0] age);
    logic [2:0] s;
    s = {1'b0, head} + 3'(SLOTS) - {1'b0, age};
    if (s >= 3'(SLOTS)) s = s - 3'(SLOTS);
    return s[1:0];
  endfunction

  // Newest slot replaces the oldest on each new record once all slots hold records
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      headQ <= 2'h0;
      wrPtrQ <= '0;
      validCount <= 2'h0;
    end else if (clkEn) begin
      if (startSlot) begin
        headQ <= (headQ == 2'(SLOTS - 1)) ? 2'h0 : headQ + 2'h1; // R7
        wrPtrQ <= '0;
        if (validCount != 2'(SLOTS)) validCount <= validCount + 2'h1;
      end else if (wrEn && wrPtrQ != AW'(DEPTH - 1)) begin
        wrPtrQ <= wrPtrQ + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (clkEn && wrEn && !startSlot) mem[headQ * DEPTH + wrPtrQ] <= wrData;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rdData <= '0;
    else if (clkEn) rdData <= mem[slotOf(headQ, rdAge) * DEPTH + rdAddr];
  end
endmodule
`default_nettype wire

// [bmct_monitor.sv]
// Top: alarms, waveform capture control, health counters and self-test sequencer
`timescale 1ns/1ns
`default_nettype none
module bmct_monitor #(
  parameter int SEC_CYC = bmct_pkg::SECOND_CYC,
  parameter int MIN_S = bmct_pkg::MINUTE_S,
  parameter int TEST_SECS = bmct_pkg::TEST_S,
  parameter int SPC = bmct_pkg::SAMPLES_PER_CYCLE
) (
  input wire logic mclk, // 50 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic clkEn, // Freezes all state when low
  input wire logic extPower, // External power present
  input wire logic sampleStrobe, // One sample of all channels
  input wire bmct_pkg::bmct_sample_type sampleIn, // Current samples
  input wire logic fourthIsGround, // Source ground variant flag, unused; fourth channel is stored as supplied
  input wire logic groundAlarmOnly, // Ground alarm only variant
  input wire logic pfAlarmEn, // Low power factor alarm enable
  input wire logic [7:0] pfLevel, // Programmed level
  input wire logic [7:0] powerFactor, // Measured power factor
  input wire logic distAlarmEn, // Distortion alarm enable
  input wire logic [6:0] distLevel, // Threshold percent
  input wire logic [6:0] distortion, // Measured percent
  input wire logic logAlarmsEn, // Log alarms as events
  input wire logic hostCapture, // Remote capture command pulse
  input wire logic [1:0] rdAge, // Record age to read
  input wire logic [8:0] rdAddr, // Sample index to read
  input wire bmct_pkg::bmct_trip_type tripIn, // Real trip pulses
  input wire logic breakerClose, // Close event pulse
  input wire logic breakerOpen, // Open event pulse
  input wire logic [31:0] timeNow, // Real time clock
  input wire logic [7:0] tempNow, // Processor temperature
  input wire logic resetKey, // Reset key pulse
  input wire logic saveKey, // Save key pulse
  input wire logic anyKey, // Any key pulse
  input wire logic testTripMode, // 1 trip test, 0 non-trip test
  input wire logic testGround, // Ground test type
  input wire logic testPickup, // Test current above a pickup
  input wire logic testTrip, // Test current reached trip
  input wire logic realAlarm, // Real phase current over alarm setting
  input wire logic [15:0] groundPu, // Real ground current per unit
  input wire logic phaseOverRating, // Phase above long rating
  input wire logic phaseOverHalfInst, // Phase above half instantaneous
  output logic pfAlarm, // Power factor alarm to display and host
  output logic distAlarm, // Distortion alarm
  output logic yellowLamp, // Alarm indicator
  output bmct_pkg::bmct_sample_type rdData, // Waveform readout
  output logic [1:0] recordsHeld, // Stored records
  output logic captureBusy, // Capture in progress
  output logic [7:0] fastTripCount, // Instantaneous plus short delay
  output logic [7:0] slowTripCount, // Overload plus ground
  output logic [15:0] closeOpCount, // Close operations
  output logic [31:0] lastOpTime, // Time of last operation
  output logic [7:0] maxTemp, // Highest temperature
  output logic testActive, // Self test running
  output logic testRefused, // Entry refused pulse
  output logic testAborted, // Abort pulse
  output logic tripOut, // Breaker trip command
  output logic relayOut, // Alarm relay
  output logic testLamp // Test cause indicator
);
  import bmct_pkg::*;
  localparam int DEPTH = SPC * TRIP_CYCLES;
  localparam int AW = $clog2(DEPTH);
  localparam logic [25:0] SEC_LAST = 26'(SEC_CYC - 1);

  // One-second tick shared by rate limit, minute and test timers
  logic [25:0] secCntQ;
  logic secTick;
  assign secTick = (secCntQ == SEC_LAST);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) secCntQ <= '0;
    else if (clkEn) secCntQ <= secTick ? '0 : secCntQ + 26'h1;
  end

  // Alarms
  logic [5:0] minCntQ;
  logic [6:0] distClamp;
  assign distClamp = (distLevel < DIST_MIN_PCT) ? DIST_MIN_PCT :
                     (distLevel > DIST_MAX_PCT) ? DIST_MAX_PCT : distLevel; // R2
  logic distEval;
  assign distEval = secTick && (minCntQ == 6'(MIN_S - 1));
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      minCntQ <= '0;
      pfAlarm <= 1'b0;
      distAlarm <= 1'b0;
      yellowLamp <= 1'b0;
    end else if (clkEn) begin
      if (secTick) minCntQ <= distEval ? '0 : minCntQ + 6'h1;
      pfAlarm <= pfAlarmEn && (powerFactor < pfLevel); // R1
      if (distEval) distAlarm <= distAlarmEn && (distortion > distClamp); // R3
      yellowLamp <= (pfAlarmEn && (powerFactor < pfLevel)) || distAlarm; // R1 R2
    end
  end

  // Capture control
  logic rateOkQ;
  logic distRise, pfRise, distPrevQ, pfPrevQ;
  assign distRise = distAlarm && !distPrevQ;
  assign pfRise = pfAlarm && !pfPrevQ;
  logic hostAccept;
  assign hostAccept = hostCapture && rateOkQ; // R6
  logic fastTrip, slowTrip, anyProtTrip;
  assign fastTrip = tripIn.instTrip || tripIn.shortTrip;
  assign slowTrip = tripIn.overloadTrip || tripIn.earthFaultTrip;
  assign anyProtTrip = fastTrip || slowTrip; // R8 R10
  logic oneCycReq;
  assign oneCycReq = hostAccept || (pfRise && logAlarmsEn); // R11

  bmct_cap_type capQ;
  logic [AW-1:0] capCntQ;
  logic [AW-1:0] capLimitQ;
  logic startSlot, wrEn;
  bmct_sample_type wrData;
  logic [CUR_W-1:0] pipeA [SPC];

  assign wrData = sampleIn; // R4
  assign startSlot = clkEn && capQ == CAP_IDLE && (anyProtTrip || oneCycReq || distRise);
  assign wrEn = sampleStrobe && capQ != CAP_IDLE;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rateOkQ <= 1'b1;
      distPrevQ <= 1'b0;
      pfPrevQ <= 1'b0;
      capQ <= CAP_IDLE;
      capCntQ <= '0;
      capLimitQ <= '0;
      captureBusy <= 1'b0;
    end else if (clkEn) begin
      distPrevQ <= distAlarm;
      pfPrevQ <= pfAlarm;
      if (hostAccept) rateOkQ <= 1'b0;
      else if (secTick) rateOkQ <= 1'b1; // R6
      unique case (capQ)
        CAP_IDLE: begin
          if (anyProtTrip) begin
            capQ <= CAP_POST; // R8
            capLimitQ <= AW'(SPC * (TRIP_CYCLES - PRE_CYCLES) - 1); // R9
            capCntQ <= '0;
          end else if (oneCycReq || distRise) begin
            capQ <= CAP_PRE; // R2 R11
            capLimitQ <= AW'(SPC - 1); // R5
            capCntQ <= '0;
          end
        end
        CAP_PRE, CAP_POST: begin
          if (sampleStrobe) begin
            if (capCntQ == capLimitQ) capQ <= CAP_IDLE;
            capCntQ <= capCntQ + 1'b1;
          end
        end
        default: capQ <= CAP_IDLE;
      endcase
      captureBusy <= capQ != CAP_IDLE;
    end
  end

  // Pre-trip cycle: the store records the five post cycles live; the held cycle
  // is a phase A history line kept here only and never written into the store.
  always_ff @(posedge mclk) begin
    if (clkEn && sampleStrobe) begin
      pipeA[0] <= sampleIn.phaseA; // R9
      for (int i = 1; i < SPC; i++) pipeA[i] <= pipeA[i-1];
    end
  end

  bmct_capture_buf #(.SLOTS(CAPTURE_SLOTS), .DEPTH(DEPTH)) uBuf (
    .mclk(mclk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .startSlot(startSlot),
    .wrEn(wrEn),
    .wrData(wrData),
    .rdAge(rdAge),
    .rdAddr(AW'(rdAddr)),
    .rdData(rdData),
    .validCount(recordsHeld)
  );

  // Health counters, counting only with external power; reset key clears them at any time
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fastTripCount <= 8'h00;
      slowTripCount <= 8'h00;
      closeOpCount <= 16'h0000;
      lastOpTime <= 32'h0;
      maxTemp <= 8'h00;
    end else if (clkEn) begin
      if (resetKey) begin
        fastTripCount <= 8'h00; // R13
        slowTripCount <= 8'h00;
        closeOpCount <= 16'h0000;
      end else if (extPower) begin // R16
        if (fastTrip && !testActive) // R12
          fastTripCount <= (fastTripCount == TRIP_WRAP) ? 8'h00 : fastTripCount + 8'h01; // R14
        if (slowTrip && !testActive) // R12
          slowTripCount <= (slowTripCount == TRIP_WRAP) ? 8'h00 : slowTripCount + 8'h01;
        if (breakerClose)
          closeOpCount <= (closeOpCount == OPS_WRAP) ? 16'h0000 : closeOpCount + 16'h0001; // R14
      end
      if (extPower && (breakerClose || breakerOpen || anyProtTrip || tripIn.otherTrip))
        lastOpTime <= timeNow; // R15
      if (extPower && tempNow > maxTemp) maxTemp <= tempNow; // R15
    end
  end

  // Self test sequencer
  bmct_test_type tstQ;
  logic [13:0] tstSecQ;
  logic abortCond;
  assign abortCond = realAlarm || (groundPu > GND_ABORT_PU) ||
                     (!testTripMode && phaseOverRating) ||
                     (testTripMode && phaseOverHalfInst); // R22
  logic alarmActive;
  assign alarmActive = pfAlarm || distAlarm || realAlarm;
  logic gndAlarmOnlyTest;
  assign gndAlarmOnlyTest = groundAlarmOnly && testGround;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tstQ <= TST_IDLE;
      tstSecQ <= '0;
      testActive <= 1'b0;
      testRefused <= 1'b0;
      testAborted <= 1'b0;
      tripOut <= 1'b0;
      relayOut <= 1'b0;
      testLamp <= 1'b0;
    end else if (clkEn) begin
      testRefused <= 1'b0;
      testAborted <= 1'b0;
      tripOut <= anyProtTrip;
      relayOut <= alarmActive;
      unique case (tstQ)
        TST_IDLE: if (saveKey) tstQ <= TST_ARMED; // R18
        TST_ARMED: begin
          if (saveKey) begin
            if (alarmActive) begin
              testRefused <= 1'b1; // R21
              tstQ <= TST_IDLE;
            end else begin
              tstQ <= TST_RUN;
              tstSecQ <= '0;
              testActive <= 1'b1;
            end
          end else if (anyKey) tstQ <= TST_IDLE;
        end
        TST_RUN: begin
          if (secTick) tstSecQ <= tstSecQ + 14'h1;
          if (testPickup || testTrip) testLamp <= 1'b1; // R19
          if (testTrip && testTripMode && !gndAlarmOnlyTest) tripOut <= 1'b1; // R20
          if ((testTrip || testPickup) && testTripMode) relayOut <= 1'b1; // R20
          if (abortCond || anyProtTrip) begin
            tstQ <= TST_IDLE; // R22
            testActive <= 1'b0;
            testAborted <= 1'b1;
          end else if ((!testPickup && tstSecQ == 14'(TEST_SECS - 1) && secTick)
                       || anyKey) begin
            tstQ <= TST_IDLE; // R17
            testActive <= 1'b0;
            testLamp <= 1'b0;
          end
        end
        default: tstQ <= TST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [bmct_host_model.sv]
// Remote host stand-in that turns bench requests into capture commands
`timescale 1ns/1ns
`default_nettype none
module bmct_host_model (
  input wire logic mclk, // Clock
  input wire logic cmdReq, // Request from bench
  output logic hostCapture // Capture command
);
  initial hostCapture = 1'b0;
  // Launched just after an edge so the command is seen whole at the next one
  always @(posedge mclk) begin
    hostCapture <= cmdReq;
  end
endmodule
`default_nettype wire

// [bmct_monitor_checker.sv]
// Concurrent checks on the monitor's ports
`timescale 1ns/1ns
`default_nettype none
module bmct_monitor_checker (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset
  input wire logic clkEn, // Enable
  input wire logic extPower, // Power
  input wire logic pfAlarmEn, // Enable
  input wire logic [7:0] pfLevel, // Level
  input wire logic [7:0] powerFactor, // Measured
  input wire logic resetKey, // Key
  input wire logic testTripMode, // Mode
  input wire logic [15:0] groundPu, // Ground
  input wire logic pfAlarm, // Alarm
  input wire logic yellowLamp, // Lamp
  input wire logic [7:0] fastTripCount, // Count
  input wire logic [15:0] closeOpCount, // Count
  input wire logic [7:0] maxTemp, // Peak
  input wire logic testActive, // Test
  input wire logic testRefused, // Pulse
  input wire logic testAborted, // Pulse
  input wire logic tripOut, // Trip
  input wire logic relayOut // Relay
);
  import bmct_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  pf_raise_a: assert property ((clkEn && pfAlarmEn && powerFactor < pfLevel) |=> pfAlarm)
    else $error("power factor alarm missing");
  pf_drop_a: assert property ((clkEn && !pfAlarmEn) |=> !pfAlarm)
    else $error("power factor alarm while disabled");
  lamp_follow_a: assert property ($rose(pfAlarm) |-> ##[0:2] yellowLamp)
    else $error("lamp not lit for alarm");
  fast_wrap_a: assert property (($past(fastTripCount) == TRIP_WRAP && fastTripCount != TRIP_WRAP)
    |-> fastTripCount == 8'h00)
    else $error("fast counter wrap wrong");
  ops_ceiling_a: assert property (closeOpCount <= OPS_WRAP)
    else $error("close counter above wrap");
  key_clear_a: assert property ((clkEn && resetKey)
    |=> (fastTripCount == 8'h00 && closeOpCount == 16'h0000))
    else $error("reset key did not clear counters");
  temp_hold_a: assert property ((!extPower && !resetKey) |=> $stable(maxTemp))
    else $error("health data changed without power");
  refuse_idle_a: assert property (testRefused |-> !testActive ##1 !testActive)
    else $error("test entered while refused");
  non_trip_a: assert property ((testActive && $past(testActive) && !testTripMode)
    |-> (!tripOut && !relayOut))
    else $error("trip or relay in non-trip test");
  gnd_abort_a: assert property (($rose(groundPu > GND_ABORT_PU) && testActive)
    |-> ##[1:3] testAborted)
    else $error("ground current did not abort test");
  cover property (testRefused);
  cover property (testAborted);
  cover property ($fell(testActive));
endmodule
bind bmct_monitor bmct_monitor_checker u_bmct_monitor_checker (.mclk, .rst_n, .clkEn,
  .extPower, .pfAlarmEn, .pfLevel, .powerFactor, .resetKey, .testTripMode, .groundPu,
  .pfAlarm, .yellowLamp, .fastTripCount, .closeOpCount, .maxTemp, .testActive,
  .testRefused, .testAborted, .tripOut, .relayOut);
`default_nettype wire

// [bmct_monitor_test.sv]
// Self-checking bench for the monitor block
`timescale 1ns/1ns
`default_nettype none
module bmct_monitor_test;
  import bmct_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, fourthIsGround = 1'b1;
  logic groundAlarmOnly = 1'b0, phaseOverRating = 1'b0, phaseOverHalfInst = 1'b0;
  logic extPower, sampleStrobe = 1'b0, pfAlarmEn, distAlarmEn, logAlarmsEn, cmdReq;
  logic hostCapture, breakerClose, breakerOpen, resetKey, saveKey, anyKey, testTripMode;
  logic testGround, testPickup, testTrip, realAlarm, pfAlarm, distAlarm, yellowLamp;
  logic captureBusy, testActive, testRefused, testAborted, tripOut, relayOut, testLamp;
  logic [7:0] pfLevel, powerFactor, tempNow, fastTripCount, slowTripCount, maxTemp;
  logic [6:0] distLevel, distortion;
  logic [1:0] rdAge, recordsHeld;
  logic [8:0] rdAddr;
  logic [15:0] groundPu, closeOpCount, k = 16'h0000;
  logic [31:0] timeNow, lastOpTime;
  bmct_sample_type sampleIn, rdData, d0, d1, d2;
  bmct_trip_type tripIn;
  int n_fail = 0, comparisons = 0, cyc = 0, nRef = 0, nAbt = 0, n;
  bmct_host_model u_bmct_host_model (.mclk, .cmdReq, .hostCapture);
  // Short second, minute and test time keep the run small
  bmct_monitor #(.SEC_CYC(10), .MIN_S(2), .TEST_SECS(3), .SPC(58)) u_bmct_monitor (.mclk,
    .rst_n, .clkEn, .extPower, .sampleStrobe, .sampleIn, .fourthIsGround, .groundAlarmOnly,
    .pfAlarmEn, .pfLevel, .powerFactor, .distAlarmEn, .distLevel, .distortion, .logAlarmsEn,
    .hostCapture, .rdAge, .rdAddr, .tripIn, .breakerClose, .breakerOpen, .timeNow, .tempNow,
    .resetKey, .saveKey, .anyKey, .testTripMode, .testGround, .testPickup, .testTrip,
    .realAlarm, .groundPu, .phaseOverRating, .phaseOverHalfInst, .pfAlarm, .distAlarm,
    .yellowLamp, .rdData, .recordsHeld, .captureBusy, .fastTripCount, .slowTripCount,
    .closeOpCount, .lastOpTime, .maxTemp, .testActive, .testRefused, .testAborted, .tripOut,
    .relayOut, .testLamp);
  // Consecutive samples make any stored record checkable by differences
  assign sampleIn = {k, k + 16'h1000, k + 16'h2000, k + 16'h3000};
  initial begin
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    sampleStrobe <= ~sampleStrobe;
    if (sampleStrobe) k <= k + 16'h0001;
    cyc++;
    nRef += int'(testRefused);
    nAbt += int'(testAborted);
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task tick(input int c);
    repeat (c) @(posedge mclk);
  endtask
  task trip(input logic [4:0] t);
    @(posedge mclk) tripIn <= t;
    @(posedge mclk) tripIn <= 5'h00;
  endtask
  task hostCap;
    @(posedge mclk) cmdReq <= 1'b1;
    @(posedge mclk) cmdReq <= 1'b0;
  endtask
  task saveTwice;
    @(posedge mclk) saveKey <= 1'b1;
    @(posedge mclk) saveKey <= 1'b0;
    @(posedge mclk) saveKey <= 1'b1;
    @(posedge mclk) saveKey <= 1'b0;
  endtask
  task waitIdle;
    n = 0;
    tick(3);
    while (captureBusy === 1'b1 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    chk(captureBusy, 1'b0, "capture never ended");
  endtask
  task readAt(input logic [1:0] age, input logic [8:0] addr, output bmct_sample_type d);
    @(posedge mclk);
    rdAge <= age;
    rdAddr <= addr;
    tick(2);
    #1 d = rdData;
  endtask
  initial begin
    {extPower, pfAlarmEn, distAlarmEn, logAlarmsEn, cmdReq, breakerClose} = 6'h20;
    {breakerOpen, resetKey, saveKey, anyKey, testTripMode, testGround} = 6'h00;
    {testPickup, testTrip, realAlarm, rdAge, rdAddr, tripIn} = '0;
    {pfLevel, powerFactor, tempNow, distLevel, distortion} = {24'h506020, 14'h0000};
    {groundPu, timeNow} = {16'h0000, 32'h0000_0000};
    tick(10);
    rst_n <= 1'b1;
    @(posedge mclk) {pfAlarmEn, powerFactor} <= {1'b1, 8'h40};
    tick(3);
    chk(pfAlarm, 1'b1, "pf alarm");
    chk(yellowLamp, 1'b1, "lamp");
    chk(recordsHeld, 2'h0, "capture without logging");
    saveTwice();
    tick(3);
    chk(nRef, 1, "refusal pulse");
    @(posedge mclk) pfAlarmEn <= 1'b0;
    @(posedge mclk) {distAlarmEn, distortion} <= {1'b1, 7'h08};
    tick(45);
    chk(distAlarm, 1'b0, "level below floor");
    @(posedge mclk) distortion <= 7'h28;
    tick(45);
    chk(distAlarm, 1'b1, "distortion alarm");
    chk(yellowLamp, 1'b1, "distortion lamp");
    waitIdle();
    chk(recordsHeld, 2'h1, "distortion capture");
    @(posedge mclk) distortion <= 7'h05;
    hostCap();
    hostCap();
    waitIdle();
    chk(recordsHeld, 2'h2, "rate limit");
    hostCap();
    waitIdle();
    hostCap();
    waitIdle();
    chk(recordsHeld, 2'h3, "three records");
    readAt(2'h0, 9'h000, d0);
    readAt(2'h0, 9'h039, d1);
    readAt(2'h2, 9'h000, d2);
    chk(d1.phaseA - d0.phaseA, 32'd57, "samples per cycle");
    chk(d0.fourth - d0.phaseA, 32'h3000, "fourth channel");
    chk(d0.phaseA > d2.phaseA, 1'b1, "record order");
    @(posedge mclk) {logAlarmsEn, pfAlarmEn} <= 2'h3;
    tick(4);
    chk(captureBusy, 1'b1, "logged alarm capture");
    waitIdle();
    @(posedge mclk) {logAlarmsEn, pfAlarmEn} <= 2'h0;
    trip(5'h01);
    tick(4);
    chk(captureBusy, 1'b0, "other trip capture");
    trip(5'h04);
    waitIdle();
    chk(n > 570, 1'b1, "trip record length");
    trip(5'h08);
    waitIdle();
    chk(fastTripCount, 8'h02, "fast trips");
    repeat (255) trip(5'h10);
    trip(5'h02);
    waitIdle();
    chk(slowTripCount, 8'h00, "slow wrap");
    @(posedge mclk) {tempNow, timeNow, breakerClose} <= {8'h45, 32'h0000_1234, 1'b1};
    @(posedge mclk) breakerClose <= 1'b0;
    tick(3);
    chk(closeOpCount, 16'h0001, "close count");
    chk(lastOpTime, 32'h0000_1234, "operation time");
    chk(maxTemp, 8'h45, "peak temperature");
    @(posedge mclk) {extPower, tempNow, timeNow, breakerOpen} <= {9'h070, 32'h5678, 1'b1};
    @(posedge mclk) breakerOpen <= 1'b0;
    tick(3);
    chk(maxTemp, 8'h45, "unpowered temperature");
    chk(lastOpTime, 32'h0000_1234, "unpowered capture");
    @(posedge mclk) {extPower, resetKey} <= 2'h3;
    @(posedge mclk) resetKey <= 1'b0;
    tick(2);
    chk({fastTripCount, slowTripCount, closeOpCount}, 32'h0, "reset key");
    saveTwice();
    tick(20);
    chk(testActive, 1'b1, "test running");
    tick(25);
    chk(testActive, 1'b0, "test time-out");
    saveTwice();
    tick(3);
    @(posedge mclk) anyKey <= 1'b1;
    @(posedge mclk) anyKey <= 1'b0;
    tick(3);
    chk(testActive, 1'b0, "key ends test");
    @(posedge mclk) {testPickup, testTrip} <= 2'h3;
    saveTwice();
    tick(5);
    chk({tripOut, relayOut, testLamp}, 3'h1, "non-trip outputs");
    @(posedge mclk) groundPu <= 16'h0066;
    tick(3);
    chk(testActive, 1'b1, "ground at limit");
    @(posedge mclk) groundPu <= 16'h0067;
    tick(4);
    chk(nAbt, 1, "ground abort");
    @(posedge mclk) {groundPu, testTripMode, testGround, testPickup, testTrip} <= 20'h0000c;
    saveTwice();
    tick(3);
    @(posedge mclk) realAlarm <= 1'b1;
    tick(4);
    chk({nAbt, testActive}, {32'd2, 1'b0}, "alarm abort");
    @(posedge mclk) {realAlarm, testGround, testPickup, testTrip} <= 4'h3;
    saveTwice();
    tick(5);
    chk(tripOut, 1'b1, "trip test");
    chk(fastTripCount, 8'h00, "test not counted");
    tally_and_finish();
  end
endmodule
`default_nettype wire
